// [dms_far_side.sv]
`timescale 1ns/1ps
module dms_far_side (
	// Clock
	input wire logic aclk,
	// Terminal levels
	output logic forward_start_input,
	output logic reverse_start_input,
	output logic output_stop_input,
	output logic [6:0] term_in,
	output logic [15:0] ext_freq_cmd,
	// Panel keys
	output logic panel_mode_req,
	output logic panel_ext_req,
	output logic panel_stop_reset_key,
	// Motor status
	output logic motor_running,
	output logic fault_active
);
	initial begin
		{forward_start_input, reverse_start_input, output_stop_input} = '0;
		{term_in, ext_freq_cmd, panel_mode_req, panel_ext_req} = '0;
		{panel_stop_reset_key, motor_running, fault_active} = '0;
	end
	// Switches move just after an edge and then stay put
	task automatic lv(input logic [5:0] v, input logic [6:0] t,
		input logic [15:0] f);
		@(posedge aclk);
		{forward_start_input, reverse_start_input} <= v[5:4];
		{output_stop_input, motor_running} <= v[3:2];
		{fault_active, panel_stop_reset_key} <= v[1:0];
		term_in <= t;
		ext_freq_cmd <= f;
	endtask : lv
	// One-cycle key press; only the panel asks for panel mode
	task automatic key(input logic m, input logic e);
		@(posedge aclk);
		panel_mode_req <= m;
		panel_ext_req <= e;
		@(posedge aclk);
		panel_mode_req <= 1'b0;
		panel_ext_req <= 1'b0;
	endtask : key
endmodule : dms_far_side

// [dms_mode_selector.sv]
// Contract
// - Setting 6 allows mode changes among all three modes while running.
// - Leaving external keeps direction and last potentiometer frequency.
// - Carried-over frequency is discarded on power loss or reset.
// - Entering external takes direction and frequency from external inputs.
// - Panel and network switching keeps direction and frequency unchanged.
// - Network changes come by network command, panel changes by panel.
// - Setting 7 forces external mode while interlock is deasserted.
// - A terminal function code 12 routes the interlock to that terminal.
// - Without such a terminal the output-stop input serves as interlock.
// - Interlock asserted permits mode switching and parameter writes.
// - Interlock deasserted holds external, refuses changes, blocks writes.
// - Interlock deasserting in panel or network enters external regardless.
// - Change to panel refused while either start input is active.
// - Setting not 7 returns shared input to its output-stop role.
// - Interlock polarity follows logic-select; values 2 to 5 invert it.
// - Panel stop/reset key resets faults while interlock holds external.
// - Priority: mode select, interlock, network, panel, comm startup last.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dms_params.svh"

module dms_mode_selector
	import dms_pkg::*;
#(
	parameter int NUM_TERM = 7,
	parameter int FREQ_W = 16
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// External terminals
	input wire logic forward_start_input,
	input wire logic reverse_start_input,
	input wire logic output_stop_input,
	input wire logic [NUM_TERM-1:0] term_in,
	input wire logic [FREQ_W-1:0] ext_freq_cmd,
	// Operator panel
	input wire logic panel_mode_req,
	input wire logic panel_ext_req,
	input wire logic panel_freq_wr,
	input wire logic [FREQ_W-1:0] panel_freq,
	input wire logic panel_stop_reset_key,
	// Motor output control
	input wire logic motor_running,
	input wire logic fault_active,
	output dms_mode_t op_mode,
	output logic dir_fwd,
	output logic dir_rev,
	output logic [FREQ_W-1:0] freq_set,
	output logic output_stop_active,
	output logic param_write_enable,
	output logic fault_reset
);

	logic [NUM_TERM+2:0] sync1_reg, sync2_reg;
	logic fwd_s, rev_s, stop_s, start_any;
	logic [NUM_TERM-1:0] term_s, func_hit;
	logic [7:0] func_reg [NUM_TERM];
	logic [7:0] func_next [NUM_TERM];
	logic [3:0] sel_reg, sel_next, logic_reg, logic_next;
	logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic [7:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next, wd;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic [31:0] rdata_reg, rdata_next;
	dms_mode_t mode_reg, mode_next;
	logic fwd_reg, fwd_next, rev_reg, rev_next;
	logic [FREQ_W-1:0] freq_reg, freq_next;
	logic stop_reg, stop_next, pwe_reg, pwe_next, frst_reg, frst_next;
	logic il_assigned, il_raw, inv, il_on, ilock_mode, il_ok;
	logic allow, to_net, to_ext, net_fw;

	assign fwd_s = sync2_reg[0];
	assign rev_s = sync2_reg[1];
	assign stop_s = sync2_reg[2];
	assign term_s = sync2_reg[NUM_TERM+2:3];
	assign start_any = fwd_s | rev_s;

	// Interlock source selection per terminal
	for (genvar i = 0; i < NUM_TERM; i++) begin : g_func
		assign func_hit[i] = (func_reg[i] == `DMS_FUNC_ILOCK);
	end

	assign il_assigned = |func_hit;
	assign il_raw = il_assigned ? |(func_hit & term_s) : stop_s;
	assign inv = (logic_reg >= `DMS_INV_LO) && (logic_reg <= `DMS_INV_HI);
	assign il_on = il_raw ^ inv;
	assign ilock_mode = (sel_reg == `DMS_SEL_ILOCK);
	assign il_ok = !ilock_mode || il_on;
	// Parameter writes need the interlock; running changes need setting 6
	assign allow = !motor_running || (sel_reg == `DMS_SEL_RUN);

	function automatic logic [31:0] merge(logic [31:0] old_v,
		logic [31:0] new_v, logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	always_comb begin
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		sel_next = sel_reg;
		logic_next = logic_reg;
		func_next = func_reg;
		to_net = 1'b0;
		to_ext = 1'b0;
		net_fw = 1'b0;
		wd = 32'h0000_0000;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (aw_got_reg && w_got_reg && !bvalid_reg) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = `DMS_RESP_OKAY;
			case (awaddr_reg)
				`DMS_OFF_MODE_SEL: begin
					// Always writable, even under the interlock
					wd = merge({28'h0000000, sel_reg}, wdata_reg, wstrb_reg);
					sel_next = wd[3:0];
				end
				`DMS_OFF_STOP_LOGIC: begin
					wd = merge({28'h0000000, logic_reg}, wdata_reg, wstrb_reg);
					if (pwe_reg) begin
						logic_next = wd[3:0];
					end else begin
						bresp_next = `DMS_RESP_SLVERR;
					end
				end
				`DMS_OFF_NET_CMD: begin
					// Commands, not parameters: the mode logic judges them
					to_net = wstrb_reg[0] && wdata_reg[`DMS_CMD_TO_NET];
					to_ext = wstrb_reg[0] && wdata_reg[`DMS_CMD_TO_EXT];
				end
				`DMS_OFF_NET_FREQ: begin
					wd = merge({{(32-FREQ_W){1'b0}}, freq_reg}, wdata_reg, wstrb_reg);
					if (pwe_reg) begin
						net_fw = 1'b1;
					end else begin
						bresp_next = `DMS_RESP_SLVERR;
					end
				end
				default: begin
					bresp_next = `DMS_RESP_SLVERR;
					for (int i = 0; i < NUM_TERM; i++) begin
						if (awaddr_reg == 8'(`DMS_OFF_FUNC_BASE + 4*i)) begin
							wd = merge({24'h000000, func_reg[i]}, wdata_reg,
								wstrb_reg);
							if (pwe_reg) begin
								bresp_next = `DMS_RESP_OKAY;
								func_next[i] = wd[7:0];
							end
						end
					end
				end
			endcase
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rdata_next = 32'h0000_0000;
			case (s_axi_araddr)
				`DMS_OFF_MODE_SEL: rdata_next[3:0] = sel_reg;
				`DMS_OFF_STOP_LOGIC: rdata_next[3:0] = logic_reg;
				`DMS_OFF_NET_FREQ: rdata_next[FREQ_W-1:0] = freq_reg;
				`DMS_OFF_FREQ_SET: rdata_next[FREQ_W-1:0] = freq_reg;
				`DMS_OFF_STATUS: begin
					rdata_next[`DMS_ST_MODE_LSB +: 2] = mode_reg;
					rdata_next[`DMS_ST_ILOCK] = il_on;
					rdata_next[`DMS_ST_STOP] = stop_reg;
					rdata_next[`DMS_ST_PWE] = pwe_reg;
					rdata_next[`DMS_ST_FWD] = fwd_reg;
					rdata_next[`DMS_ST_REV] = rev_reg;
				end
				default: begin
					for (int i = 0; i < NUM_TERM; i++) begin
						if (s_axi_araddr == 8'(`DMS_OFF_FUNC_BASE + 4*i)) begin
							rdata_next[7:0] = func_reg[i];
						end
					end
				end
			endcase
		end
	end

	// Mode decision, highest priority first
	always_comb begin
		mode_next = mode_reg;
		if (sel_reg == `DMS_SEL_PANEL) begin
			mode_next = DMS_PANEL;
		end else if (sel_reg == `DMS_SEL_COMB1 || sel_reg == `DMS_SEL_COMB2) begin
			mode_next = DMS_EXT;
		end else if (!il_ok) begin
			// Start inputs do not matter here
			mode_next = DMS_EXT;
		end else if (allow && to_net && mode_reg != DMS_NET) begin
			mode_next = DMS_NET;
		end else if (allow && to_ext && mode_reg == DMS_NET) begin
			mode_next = DMS_EXT;
		end else if (allow && panel_mode_req && mode_reg != DMS_PANEL
			&& sel_reg != `DMS_SEL_EXT && !start_any) begin
			mode_next = DMS_PANEL;
		end else if (allow && panel_ext_req && mode_reg == DMS_PANEL) begin
			mode_next = DMS_EXT;
		end
		fwd_next = fwd_reg;
		rev_next = rev_reg;
		freq_next = freq_reg;
		if (mode_next == DMS_EXT) begin
			// Tracked every cycle so the last value is carried over on exit
			fwd_next = fwd_s && !rev_s;
			rev_next = rev_s && !fwd_s;
			freq_next = ext_freq_cmd;
		end else if (mode_next == mode_reg) begin
			// No loads on a switchover edge, so values carry over
			if (mode_reg == DMS_NET && net_fw) begin
				freq_next = wd[FREQ_W-1:0];
			end else if (mode_reg == DMS_PANEL && panel_freq_wr) begin
				freq_next = panel_freq;
			end
		end
		stop_next = (stop_s ^ inv) && !(ilock_mode && !il_assigned);
		pwe_next = il_ok;
		frst_next = panel_stop_reset_key && fault_active
			&& (mode_reg == DMS_PANEL || !il_ok);
	end

	always_ff @(posedge aclk) begin
		sync1_reg <= {term_in, output_stop_input, reverse_start_input,
			forward_start_input};
		sync2_reg <= sync1_reg;
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `DMS_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			sel_reg <= `DMS_RST_MODE_SEL;
			logic_reg <= `DMS_RST_STOP_LOGIC;
			for (int i = 0; i < NUM_TERM; i++) begin
				func_reg[i] <= `DMS_RST_FUNC;
			end
			mode_reg <= DMS_EXT;
			fwd_reg <= 1'b0;
			rev_reg <= 1'b0;
			freq_reg <= '0;
			stop_reg <= 1'b0;
			pwe_reg <= 1'b1;
			frst_reg <= 1'b0;
		end else begin
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			sel_reg <= sel_next;
			logic_reg <= logic_next;
			func_reg <= func_next;
			mode_reg <= mode_next;
			fwd_reg <= fwd_next;
			rev_reg <= rev_next;
			freq_reg <= freq_next;
			stop_reg <= stop_next;
			pwe_reg <= pwe_next;
			frst_reg <= frst_next;
		end
	end

	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready = !w_got_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = `DMS_RESP_OKAY;
	assign op_mode = mode_reg;
	assign dir_fwd = fwd_reg;
	assign dir_rev = rev_reg;
	assign freq_set = freq_reg;
	assign output_stop_active = stop_reg;
	assign param_write_enable = pwe_reg;
	assign fault_reset = frst_reg;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_ilock_force_ext: assert property ((ilock_mode && !il_on) |=>
		mode_reg == DMS_EXT) else $error("interlock did not force external");
	a_run_no_change: assert property ((motor_running &&
		(sel_reg == 4'h0 || sel_reg == `DMS_SEL_EXT)) |=> $stable(mode_reg))
		else $error("mode changed while running");
	a_panel_start_block: assert property ((start_any &&
		mode_reg != DMS_PANEL && sel_reg != `DMS_SEL_PANEL) |=>
		mode_reg != DMS_PANEL) else $error("panel entered with start active");
	a_leave_ext_keep: assert property ((mode_reg == DMS_EXT ##1
		mode_reg != DMS_EXT) |-> $stable(fwd_reg) && $stable(rev_reg)
		&& $stable(freq_reg)) else $error("values lost leaving external");
	a_enter_ext_take: assert property ((mode_reg != DMS_EXT ##1
		mode_reg == DMS_EXT) |-> freq_reg == $past(ext_freq_cmd)
		&& fwd_reg == ($past(fwd_s) && !$past(rev_s)))
		else $error("external values not taken");
	a_pn_keep: assert property ((mode_reg != DMS_EXT ##1
		(mode_reg != DMS_EXT && mode_reg != $past(mode_reg))) |->
		$stable(freq_reg) && $stable(fwd_reg))
		else $error("panel/network switch changed values");
	a_param_lock: assert property (!pwe_reg |=>
		$stable(logic_reg) && $stable(func_reg[0]))
		else $error("parameter written under interlock");
	a_stop_role: assert property ((!ilock_mode && (stop_s ^ inv)) |=>
		output_stop_active) else $error("output stop role not restored");
	a_fault_reset: assert property ((panel_stop_reset_key &&
		fault_active && !il_ok) |=> fault_reset)
		else $error("stop key did not reset fault");
	a_bresp_follows: assert property ((aw_got_reg && w_got_reg &&
		!bvalid_reg && awaddr_reg == `DMS_OFF_STOP_LOGIC && !pwe_reg) |=>
		s_axi_bvalid && s_axi_bresp == `DMS_RESP_SLVERR)
		else $error("locked write not refused");

endmodule : dms_mode_selector

// [dms_params.svh]
`ifndef DMS_PARAMS_SVH
`define DMS_PARAMS_SVH

// Register byte offsets
`define DMS_OFF_MODE_SEL 8'h00
`define DMS_OFF_STOP_LOGIC 8'h04
`define DMS_OFF_NET_CMD 8'h08
`define DMS_OFF_NET_FREQ 8'h0c
`define DMS_OFF_STATUS 8'h10
`define DMS_OFF_FREQ_SET 8'h14
`define DMS_OFF_FUNC_BASE 8'h20

// Reset values
`define DMS_RST_MODE_SEL 4'h0
`define DMS_RST_STOP_LOGIC 4'h0
`define DMS_RST_FUNC 8'h00

// Mode-select codes
`define DMS_SEL_PANEL 4'h1
`define DMS_SEL_EXT 4'h2
`define DMS_SEL_COMB1 4'h3
`define DMS_SEL_COMB2 4'h4
`define DMS_SEL_RUN 4'h6
`define DMS_SEL_ILOCK 4'h7

// Input function code of the panel interlock
`define DMS_FUNC_ILOCK 8'h0c

// Output-stop logic-select range that inverts polarity
`define DMS_INV_LO 4'h2
`define DMS_INV_HI 4'h5

// Network command register bits
`define DMS_CMD_TO_NET 0
`define DMS_CMD_TO_EXT 1

// Status register fields
`define DMS_ST_MODE_LSB 0
`define DMS_ST_ILOCK 2
`define DMS_ST_STOP 3
`define DMS_ST_PWE 4
`define DMS_ST_FWD 5
`define DMS_ST_REV 6

// AXI responses
`define DMS_RESP_OKAY 2'b00
`define DMS_RESP_SLVERR 2'b10

`endif

// [dms_pkg.sv]
package dms_pkg;
	typedef enum logic [1:0] {DMS_EXT, DMS_PANEL, DMS_NET} dms_mode_t;
endpackage : dms_pkg

// [tb_dms_mode_selector.sv]
`timescale 1ns/1ps
`include "dms_params.svh"
module tb_dms_mode_selector;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic forward_start_input, reverse_start_input, output_stop_input;
	logic [6:0] term_in;
	logic [15:0] ext_freq_cmd, freq_set;
	logic panel_mode_req, panel_ext_req, panel_stop_reset_key;
	logic motor_running, fault_active;
	logic [1:0] op_mode;
	logic dir_fwd, dir_rev, output_stop_active;
	logic param_write_enable, fault_reset;
	logic [31:0] sd = 32'h982e475a;
	logic [15:0] fp = 16'h0;
	logic [5:0] pv = 6'h0;
	int em, ed, ef, tn, error_cnt, checked;
	localparam logic [1:0] OK = `DMS_RESP_OKAY;
	localparam logic [1:0] ERR = `DMS_RESP_SLVERR;

	dms_mode_selector u_dms_mode_selector (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .forward_start_input, .reverse_start_input,
		.output_stop_input, .term_in, .ext_freq_cmd, .panel_mode_req,
		.panel_ext_req, .panel_freq_wr(1'b0), .panel_freq(16'h0),
		.panel_stop_reset_key, .motor_running, .fault_active, .op_mode,
		.dir_fwd, .dir_rev, .freq_set, .output_stop_active,
		.param_write_enable, .fault_reset);
	dms_far_side u_dms_far_side (.aclk, .forward_start_input,
		.reverse_start_input, .output_stop_input, .term_in, .ext_freq_cmd,
		.panel_mode_req, .panel_ext_req, .panel_stop_reset_key,
		.motor_running, .fault_active);

	initial begin
		forever #25 aclk = ~aclk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp

	// Model: external mode follows the pins, other modes hold
	task automatic chk();
		if (em == 0) begin
			ed = {pv[4], pv[5]};
			ef = fp;
		end
		cmp({30'h0, op_mode}, em);
		cmp({30'h0, dir_rev, dir_fwd}, ed);
		cmp({16'h0, freq_set}, ef);
	endtask : chk

	task automatic st();
		repeat (5) @(posedge aclk);
	endtask : st

	task automatic pin(input logic [5:0] v, input logic [6:0] t);
		sd = lfsr(sd);
		fp = sd[15:0];
		pv = v;
		// External mode tracks the pins every cycle, not only at a check
		if (em == 0) begin
			ed = {v[4], v[5]};
			ef = fp;
		end
		u_dms_far_side.lv(v, t, fp);
		st();
	endtask : pin

	task automatic key(input logic m, input logic e);
		u_dms_far_side.key(m, e);
		st();
	endtask : key

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		cmp({30'h0, s_axi_bresp}, er);
		s_axi_bready <= 1'b0;
		st();
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		cmp(s_axi_rdata, e);
		cmp({30'h0, s_axi_rresp}, OK);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic rst();
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		em = 0;
		cmp({op_mode, dir_rev, dir_fwd, freq_set}, 0);
		aresetn <= 1'b1;
	endtask : rst

	task automatic done();
		tn++;
		$display("test %0d done", tn);
	endtask : done

	task automatic end_of_test();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		end_of_test();
	end

	initial begin
		rst();
		rd(`DMS_OFF_MODE_SEL, 0);
		rd(8'h3c, 0);
		wr(8'h3c, sd, ERR);
		cmp({31'h0, param_write_enable}, 1);
		done();
		// Changes while running
		wr(`DMS_OFF_MODE_SEL, 6, OK);
		pin(6'b100100, 0);
		chk();
		wr(`DMS_OFF_NET_CMD, 1, OK);
		em = 2;
		chk();
		sd = lfsr(sd);
		wr(`DMS_OFF_NET_FREQ, sd, OK);
		ef = sd[15:0];
		rd(`DMS_OFF_FREQ_SET, sd[15:0]);
		pin(6'b000100, 0);
		chk();
		key(1, 0);
		em = 1;
		chk();
		wr(`DMS_OFF_NET_CMD, 1, OK);
		em = 2;
		chk();
		wr(`DMS_OFF_NET_CMD, 2, OK);
		em = 0;
		chk();
		done();
		// Stopped-only setting refuses while running or started
		wr(`DMS_OFF_MODE_SEL, 0, OK);
		wr(`DMS_OFF_NET_CMD, 1, OK);
		chk();
		pin(6'b100000, 0);
		key(1, 0);
		chk();
		done();
		// Interlock on the shared output-stop pin
		wr(`DMS_OFF_MODE_SEL, 7, OK);
		pin(6'b001000, 0);
		key(1, 0);
		em = 1;
		chk();
		cmp({31'h0, output_stop_active}, 0);
		pin(6'b100000, 0);
		em = 0;
		chk();
		cmp({31'h0, param_write_enable}, 0);
		wr(`DMS_OFF_STOP_LOGIC, 2, ERR);
		key(1, 0);
		wr(`DMS_OFF_NET_CMD, 1, OK);
		chk();
		pin(6'b000011, 0);
		cmp({31'h0, fault_reset}, 1);
		wr(`DMS_OFF_MODE_SEL, 7, OK);
		done();
		// Shared pin returns to output stop
		pin(6'b001000, 0);
		cmp({31'h0, output_stop_active}, 0);
		wr(`DMS_OFF_MODE_SEL, 0, OK);
		cmp({31'h0, output_stop_active}, 1);
		wr(`DMS_OFF_MODE_SEL, 7, OK);
		cmp({31'h0, output_stop_active}, 0);
		done();
		// Interlock moved to a terminal, then inverted
		wr(`DMS_OFF_FUNC_BASE, 32'h0c, OK);
		pin(6'b000000, 7'h01);
		key(1, 0);
		em = 1;
		chk();
		pin(6'b000000, 7'h00);
		em = 0;
		chk();
		pin(6'b000000, 7'h01);
		wr(`DMS_OFF_STOP_LOGIC, 2, OK);
		cmp({31'h0, param_write_enable}, 0);
		pin(6'b000000, 7'h00);
		key(1, 0);
		em = 1;
		chk();
		done();
		rst();
		done();
		end_of_test();
	end
endmodule : tb_dms_mode_selector
